// file: rtl/afe_ready_cfg_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "afe_regs.svh"

//Contract
// - latency set: skip three rate periods first
// - latency clear: pulse every period from start
// - idle pin high or released per drive bit
// - source field picks which channel pulses
// - mode 00 follows lagging channel, latches both
// - mode 00, channel off: no pulses
// - independent modes freeze data during reads
// - linked output frozen while read runs
// - mode 11, one channel off: only other pulses
// - status read sets flags, events clear them
// - mode 00 clears both flags together
// - loop field steers read address advance
// - prescaler divides master clock by 1-8
// - oversampling ratio 32 to 256
// - width bit: 24 or 16 bit word
// - modulator bits routed to their pins
// - reset bits hold channel converters
// - shutdown bits power channels down
// - dither enable per channel, default on
// - reference select disables internal reference
// - clock select bypasses crystal oscillator
// - positive phase makes channel 0 lag
module afe_ready_cfg_regs #(
    parameter int MOD_DIV = `AFE_MOD_CLK_DIV
) (
    input  wire logic           core_clk_i,
    input  wire logic           rst_b_i,
    input  wire logic           frame_start_i,
    input  wire logic [4:0]     frame_addr_i,
    input  wire logic           frame_active_i,
    input  wire logic           reg_rd_i,
    input  wire logic           reg_wr_i,
    input  wire logic [7:0]     reg_wdata_i,
    input  wire logic [7:0]     phase_code_i,
    input  wire logic [23:0]    ch0_result_i,
    input  wire logic [23:0]    ch1_result_i,
    input  wire logic [1:0]     mod_bit_i,
    output logic [7:0]          reg_rdata_o,
    output logic [4:0]          reg_addr_o,
    output afe_pkg::afe_cfg_t   cfg_o,
    output afe_pkg::afe_status_t status_o,
    output logic                ready_pin_o,
    output logic                ready_pin_oe_o,
    output logic                modulator_data_pin0_o,
    output logic                modulator_data_pin1_o,
    output logic                internal_master_clock_o,
    output logic                modulator_clock_o,
    output logic                sample_rate_clock_o
);
    import afe_pkg::*;

    function automatic logic [4:0] next_addr(input logic [4:0] a, input afe_loop_t lp);
        logic [4:0] first;
        logic [4:0] last;
        first = `AFE_ADDR_CH0_FIRST;
        last  = `AFE_ADDR_CONFIG_CHANNEL_POWER;
        case (lp)
            AFE_LOOP_GROUP: begin
                if (a <= `AFE_ADDR_CH0_LAST) begin
                    last = `AFE_ADDR_CH0_LAST;
                end else if (a <= `AFE_ADDR_CH1_LAST) begin
                    first = `AFE_ADDR_CH1_FIRST;
                    last  = `AFE_ADDR_CH1_LAST;
                end else if (a <= `AFE_ADDR_PHG_LAST) begin
                    first = `AFE_ADDR_CTL_FIRST;
                    last  = `AFE_ADDR_PHG_LAST;
                end else begin
                    first = `AFE_ADDR_STATUS;
                end
            end
            AFE_LOOP_TYPE: begin
                if (a <= `AFE_ADDR_CH1_LAST) begin
                    last = `AFE_ADDR_CH1_LAST;
                end else begin
                    first = `AFE_ADDR_CTL_FIRST;
                end
            end
            default: begin
            end
        endcase
        if (lp == AFE_LOOP_SAME) begin
            next_addr = a;
        end else if (a >= last) begin
            next_addr = first;
        end else begin
            next_addr = a + 5'h01;
        end
    endfunction

    // 16-bit word: low byte reads zero
    function automatic logic [7:0] data_byte(input logic [23:0] w, input logic wide,
                                             input logic [1:0] idx);
        case (idx)
            2'h0:    data_byte = w[23:16];
            2'h1:    data_byte = w[15:8];
            2'h2:    data_byte = wide ? w[7:0] : 8'h00;
            default: data_byte = 8'h00;
        endcase
    endfunction

    afe_status_t status_q;
    afe_status_t status_d;
    afe_cfg_t    cfg_q;
    afe_cfg_t    cfg_d;
    logic [4:0]  addr_q;
    logic [4:0]  addr_d;
    logic [7:0]  rdata_d;
    logic [23:0] live_q [2];
    logic [23:0] live_d [2];
    logic [23:0] out_q [2];
    logic [23:0] out_d [2];
    logic [3:0]  pulse_q;
    logic [3:0]  pulse_d;
    logic        pin_d;
    logic        oe_d;
    logic [2:0]  clk_d;
    logic [2:0]  clk_q;
    logic [1:0]  mod_pin_d;
    logic [1:0]  mod_pin_q;

    logic        internal_master_clock_tick;
    logic        mod_tick;
    logic [1:0]  dr_tick;
    logic [1:0]  ch_ready;
    logic [1:0]  ch_run;
    logic        ch0_lags;
    logic        lag_ev;
    logic        pin_ev;
    logic [1:0]  flag_clr;
    logic [4:0]  cur_addr;
    logic [1:0]  ch_idx;

    afe_rate_gen #(
        .MOD_DIV (MOD_DIV)
    ) u_rate (
        .core_clk_i         (core_clk_i),
        .rst_b_i            (rst_b_i),
        .mclk_divider_i     (cfg_q.mclk_divider),
        .oversample_ratio_i (cfg_q.oversample_ratio),
        .phase_code_i       (phase_code_i),
        .internal_master_clock_tick_o       (internal_master_clock_tick),
        .mod_tick_o         (mod_tick),
        .dr_tick_o          (dr_tick)
    );

    for (genvar g = 0; g < 2; g++) begin : g_ch
        afe_settle_track u_trk (
            .core_clk_i    (core_clk_i),
            .rst_b_i       (rst_b_i),
            .dr_tick_i     (dr_tick[g]),
            .hold_i        (cfg_q.channel_hold_sel[g] | cfg_q.channel_power_down[g]),
            .latency_sel_i (status_q.settle_latency_sel),
            .ready_o       (ch_ready[g])
        );
    end

    always_comb begin
        ch_run   = ~(cfg_q.channel_hold_sel | cfg_q.channel_power_down);
        ch0_lags = !phase_code_i[`AFE_PHASE_SIGN] && (phase_code_i != 8'h00);
        lag_ev   = (ch0_lags ? ch_ready[0] : ch_ready[1]) && (&ch_run);
        case (status_q.ready_pin_source)
            AFE_SRC_LAG: begin
                pin_ev   = lag_ev;
                flag_clr = {2{lag_ev}};
            end
            AFE_SRC_CH0: begin
                pin_ev   = ch_ready[0];
                flag_clr = ch_ready;
            end
            AFE_SRC_CH1: begin
                pin_ev   = ch_ready[1];
                flag_clr = ch_ready;
            end
            default: begin
                pin_ev   = |ch_ready;
                flag_clr = ch_ready;
            end
        endcase
    end

    always_comb begin
        cur_addr = frame_start_i ? frame_addr_i : addr_q;
        addr_d   = cur_addr;
        status_d = status_q;
        cfg_d    = cfg_q;
        rdata_d  = reg_rdata_o;
        ch_idx   = 2'h0;
        if (reg_wr_i) begin
            case (cur_addr)
                `AFE_ADDR_STATUS: begin
                    status_d = afe_status_t'((reg_wdata_i & `AFE_STATUS_WR_MASK)
                               | (status_q & ~`AFE_STATUS_WR_MASK));
                end
                `AFE_ADDR_CONFIG_CLOCK_WIDTH: begin
                    cfg_d[15:8] = reg_wdata_i;
                end
                `AFE_ADDR_CONFIG_CHANNEL_POWER: begin
                    cfg_d[7:0] = reg_wdata_i;
                end
                default: begin
                end
            endcase
            addr_d = next_addr(cur_addr, AFE_LOOP_MAP);
        end
        if (reg_rd_i) begin
            if (cur_addr <= `AFE_ADDR_CH0_LAST) begin
                ch_idx  = 2'(cur_addr - `AFE_ADDR_CH0_FIRST);
                rdata_d = data_byte(out_q[0], cfg_q.word_width_sel[0], ch_idx);
            end else if (cur_addr <= `AFE_ADDR_CH1_LAST) begin
                ch_idx  = 2'(cur_addr - `AFE_ADDR_CH1_FIRST);
                rdata_d = data_byte(out_q[1], cfg_q.word_width_sel[1], ch_idx);
            end else if (cur_addr == `AFE_ADDR_STATUS) begin
                rdata_d = status_q;
                status_d.ready_flags = 2'h3;
            end else if (cur_addr == `AFE_ADDR_CONFIG_CLOCK_WIDTH) begin
                rdata_d = cfg_q[15:8];
            end else if (cur_addr == `AFE_ADDR_CONFIG_CHANNEL_POWER) begin
                rdata_d = cfg_q[7:0];
            end else begin
                rdata_d = 8'h00;
            end
            addr_d = next_addr(cur_addr, status_q.addr_loop);
        end
        // event beats read-side set: none lost
        status_d.ready_flags = status_d.ready_flags & ~flag_clr;
    end

    always_comb begin
        live_d[0] = live_q[0];
        live_d[1] = live_q[1];
        if (status_q.ready_pin_source == AFE_SRC_LAG) begin
            if (lag_ev) begin
                live_d[0] = ch0_result_i;
                live_d[1] = ch1_result_i;
            end
        end else begin
            if (ch_ready[0]) begin
                live_d[0] = ch0_result_i;
            end
            if (ch_ready[1]) begin
                live_d[1] = ch1_result_i;
            end
        end
        // frozen for the whole frame
        out_d[0] = frame_active_i ? out_q[0] : live_d[0];
        out_d[1] = frame_active_i ? out_q[1] : live_d[1];
    end

    always_comb begin
        pulse_d = (pulse_q != 4'h0) ? pulse_q - 4'h1 : 4'h0;
        if (pin_ev) begin
            pulse_d = `AFE_PULSE_CYCLES;
        end
        pin_d     = (pulse_d == 4'h0);
        oe_d      = (pulse_d != 4'h0) || status_q.ready_idle_drive;
        clk_d     = {internal_master_clock_tick, mod_tick, dr_tick[1]};
        mod_pin_d = mod_bit_i & cfg_q.modulator_pin_enable;
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            status_q <= afe_status_t'(`AFE_STATUS_RST);
            cfg_q <= afe_cfg_t'({`AFE_CONFIG_CLOCK_WIDTH_RST, `AFE_CONFIG_CHANNEL_POWER_RST});
            addr_q <= `AFE_ADDR_CH0_FIRST;
            reg_rdata_o <= 8'h00;
            live_q[0] <= 24'h00_0000;
            live_q[1] <= 24'h00_0000;
            out_q[0] <= 24'h00_0000;
            out_q[1] <= 24'h00_0000;
            pulse_q <= 4'h0;
            ready_pin_o <= 1'b1;
            ready_pin_oe_o <= 1'b0;
            clk_q <= 3'h0;
            mod_pin_q <= 2'h0;
        end else begin
            status_q <= status_d;
            cfg_q <= cfg_d;
            addr_q <= addr_d;
            reg_rdata_o <= rdata_d;
            live_q[0] <= live_d[0];
            live_q[1] <= live_d[1];
            out_q[0] <= out_d[0];
            out_q[1] <= out_d[1];
            pulse_q <= pulse_d;
            ready_pin_o <= pin_d;
            ready_pin_oe_o <= oe_d;
            clk_q <= clk_d;
            mod_pin_q <= mod_pin_d;
        end
    end

    // outputs straight from flip-flops
    always_comb begin
        reg_addr_o = addr_q;
        cfg_o = cfg_q;
        status_o = status_q;
        modulator_data_pin0_o = mod_pin_q[0];
        modulator_data_pin1_o = mod_pin_q[1];
        internal_master_clock_o = clk_q[2];
        modulator_clock_o = clk_q[1];
        sample_rate_clock_o = clk_q[0];
    end

endmodule
`default_nettype wire

// file: rtl/afe_regs.svh
`ifndef AFE_REGS_SVH
`define AFE_REGS_SVH

`define AFE_ADDR_CH0_FIRST   5'h00
`define AFE_ADDR_CH0_LAST    5'h02
`define AFE_ADDR_CH1_FIRST   5'h03
`define AFE_ADDR_CH1_LAST    5'h05
`define AFE_ADDR_CTL_FIRST   5'h06
`define AFE_ADDR_PHG_LAST    5'h08
`define AFE_ADDR_STATUS      5'h09
`define AFE_ADDR_CONFIG_CLOCK_WIDTH     5'h0A
`define AFE_ADDR_CONFIG_CHANNEL_POWER     5'h0B

`define AFE_STATUS_RST       8'hA3
`define AFE_CONFIG_CLOCK_WIDTH_RST      8'h10
`define AFE_CONFIG_CHANNEL_POWER_RST      8'h0C

`define AFE_STATUS_WR_MASK   8'hFC
`define AFE_SETTLE_PERIODS   2'h3
`define AFE_PULSE_CYCLES     4'h4
`define AFE_MOD_CLK_DIV      4
`define AFE_OSR_BASE_MASK    8'h1F
`define AFE_PHASE_SIGN       7

`endif

// file: rtl/afe_pkg.sv
package afe_pkg;

    typedef enum logic [1:0] {
        AFE_SRC_LAG  = 2'h0,
        AFE_SRC_CH0  = 2'h1,
        AFE_SRC_CH1  = 2'h2,
        AFE_SRC_BOTH = 2'h3
    } afe_src_t;

    typedef enum logic [1:0] {
        AFE_LOOP_SAME  = 2'h0,
        AFE_LOOP_GROUP = 2'h1,
        AFE_LOOP_TYPE  = 2'h2,
        AFE_LOOP_MAP   = 2'h3
    } afe_loop_t;

    typedef struct packed {
        afe_loop_t  addr_loop;
        logic       settle_latency_sel;
        logic       ready_idle_drive;
        afe_src_t   ready_pin_source;
        logic [1:0] ready_flags;
    } afe_status_t;

    typedef struct packed {
        logic [1:0] mclk_divider;
        logic [1:0] oversample_ratio;
        logic [1:0] word_width_sel;
        logic [1:0] modulator_pin_enable;
        logic [1:0] channel_hold_sel;
        logic [1:0] channel_power_down;
        logic [1:0] channel_dither_enable;
        logic       external_reference_sel;
        logic       external_clock_sel;
    } afe_cfg_t;

endpackage

// file: rtl/afe_rate_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "afe_regs.svh"

module afe_rate_gen #(
    parameter int MOD_DIV = `AFE_MOD_CLK_DIV
) (
    input  wire logic       core_clk_i,
    input  wire logic       rst_b_i,
    input  wire logic [1:0] mclk_divider_i,
    input  wire logic [1:0] oversample_ratio_i,
    input  wire logic [7:0] phase_code_i,
    output logic            internal_master_clock_tick_o,
    output logic            mod_tick_o,
    output logic [1:0]      dr_tick_o
);
    import afe_pkg::*;

    initial begin
        if (MOD_DIV < 1 || MOD_DIV > 16) begin
            $error("MOD_DIV out of range");
        end
    end

    logic [2:0] pre_q;
    logic [2:0] pre_d;
    logic [3:0] mod_q;
    logic [3:0] mod_d;
    logic [7:0] osr_q;
    logic [7:0] osr_d;
    logic [2:0] pre_mask;
    logic [7:0] osr_mask;

    always_comb begin
        pre_mask     = 3'((4'h1 << mclk_divider_i) - 4'h1);
        osr_mask     = 8'((9'(`AFE_OSR_BASE_MASK) << oversample_ratio_i) | 9'h01F);
        internal_master_clock_tick_o = ((pre_q & pre_mask) == pre_mask);
        mod_tick_o   = internal_master_clock_tick_o && (mod_q == 4'(MOD_DIV - 1));
        pre_d        = pre_q + 3'h1;
        mod_d        = mod_q;
        osr_d        = osr_q;
        if (internal_master_clock_tick_o) begin
            mod_d = mod_tick_o ? 4'h0 : mod_q + 4'h1;
        end
        if (mod_tick_o) begin
            osr_d = (osr_q >= osr_mask) ? 8'h00 : osr_q + 8'h01;
        end
        // masked phase: ch0 offset in period
        dr_tick_o[1] = mod_tick_o && (osr_q == 8'h00);
        dr_tick_o[0] = mod_tick_o && (osr_q == (phase_code_i & osr_mask));
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            pre_q <= 3'h0;
            mod_q <= 4'h0;
            osr_q <= 8'h00;
        end else begin
            pre_q <= pre_d;
            mod_q <= mod_d;
            osr_q <= osr_d;
        end
    end

endmodule
`default_nettype wire

// file: rtl/afe_settle_track.sv
`timescale 1ns/1ps
`default_nettype none
`include "afe_regs.svh"

module afe_settle_track (
    input  wire logic core_clk_i,
    input  wire logic rst_b_i,
    input  wire logic dr_tick_i,
    input  wire logic hold_i,
    input  wire logic latency_sel_i,
    output logic      ready_o
);
    import afe_pkg::*;

    typedef enum logic [1:0] {
        AFE_ST_HOLD = 2'h0,
        AFE_ST_WAIT = 2'h1,
        AFE_ST_RUN  = 2'h3
    } afe_settle_t;

    afe_settle_t st_q;
    afe_settle_t st_d;
    logic [1:0]  cnt_q;
    logic [1:0]  cnt_d;
    logic        rdy_d;

    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        rdy_d = 1'b0;
        case (st_q)
            AFE_ST_HOLD: begin
                cnt_d = 2'h0;
                if (!hold_i) begin
                    st_d = latency_sel_i ? AFE_ST_WAIT : AFE_ST_RUN;
                end
            end
            AFE_ST_WAIT: begin
                if (dr_tick_i) begin
                    cnt_d = cnt_q + 2'h1;
                    if (cnt_q == `AFE_SETTLE_PERIODS - 2'h1) begin
                        st_d = AFE_ST_RUN;
                    end
                end
            end
            AFE_ST_RUN: begin
                rdy_d = dr_tick_i;
            end
            default: begin
                st_d = AFE_ST_HOLD;
            end
        endcase
        if (hold_i) begin
            st_d  = AFE_ST_HOLD;
            rdy_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            st_q    <= AFE_ST_HOLD;
            cnt_q   <= 2'h0;
            ready_o <= 1'b0;
        end else begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            ready_o <= rdy_d;
        end
    end

endmodule
`default_nettype wire

// file: bench/afe_ready_cfg_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "afe_regs.svh"
module afe_rcr_asserts #(
    parameter int MOD_DIV = 4
) (
    input wire logic                 core_clk_i,
    input wire logic                 rst_b_i,
    input wire logic                 frame_start_i,
    input wire logic [4:0]           frame_addr_i,
    input wire logic                 reg_rd_i,
    input wire logic [1:0]           mod_bit_i,
    input wire logic [4:0]           reg_addr_o,
    input wire afe_pkg::afe_cfg_t    cfg_o,
    input wire afe_pkg::afe_status_t status_o,
    input wire logic                 ready_pin_o,
    input wire logic                 ready_pin_oe_o,
    input wire logic                 modulator_data_pin0_o,
    input wire logic                 modulator_data_pin1_o,
    input wire logic                 sample_rate_clock_o
);
    import afe_pkg::*;
    logic [4:0]  cur_a;
    logic        st_rd;
    logic [15:0] per, gap_q, gap_d;
    logic [3:0]  lnk_q, lnk_d, rt_q, rt_d;
    logic        seen_q, seen_d;
    // linked-off cycles, saturating
    always_comb begin
        cur_a = frame_start_i ? frame_addr_i : reg_addr_o;
        st_rd = reg_rd_i && (cur_a == `AFE_ADDR_STATUS);
        per = 16'((32 << cfg_o.oversample_ratio) * MOD_DIV * (1 << cfg_o.mclk_divider));
        rt_d = {cfg_o.mclk_divider, cfg_o.oversample_ratio};
        gap_d = sample_rate_clock_o ? 16'h0001 : gap_q + 16'h0001;
        // rate change voids gap
        seen_d = (rt_d != rt_q) ? 1'b0 : (sample_rate_clock_o | seen_q);
        lnk_d = lnk_q;
        if (status_o.ready_pin_source != AFE_SRC_LAG ||
            !(|{cfg_o.channel_hold_sel, cfg_o.channel_power_down})) begin
            lnk_d = 4'h0;
        end else if (lnk_q != 4'hF) begin
            lnk_d = lnk_q + 4'h1;
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            gap_q <= 16'h0000;
            rt_q <= 4'h0;
            seen_q <= 1'b0;
            lnk_q <= 4'h0;
        end else begin
            gap_q <= gap_d;
            rt_q <= rt_d;
            seen_q <= seen_d;
            lnk_q <= lnk_d;
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_low4;
        !ready_pin_o [*4];
    endsequence
    AST_PULSE_LEN: assert property ($fell(ready_pin_o) |-> s_low4)
        else $error("short ready pulse");
    AST_PULSE_OE: assert property (!ready_pin_o |-> ready_pin_oe_o)
        else $error("ready pulse not driven");
    AST_IDLE: assert property (ready_pin_o && $past(ready_pin_o)
        && $stable(status_o.ready_idle_drive) |-> ready_pin_oe_o == status_o.ready_idle_drive)
        else $error("idle pin drive wrong");
    AST_LINK_OFF: assert property (lnk_q >= 4'h4 |-> !$fell(ready_pin_o))
        else $error("linked pulse with channel off");
    AST_FLAG_SET: assert property ($rose(status_o.ready_flags[0])
        || $rose(status_o.ready_flags[1]) |-> $past(st_rd))
        else $error("flag set without status read");
    AST_LINK_FLAGS: assert property (status_o.ready_pin_source == AFE_SRC_LAG
        && $stable(status_o.ready_pin_source) && $past(status_o.ready_flags) == 2'h3
        && status_o.ready_flags != 2'h3 |-> status_o.ready_flags == 2'h0)
        else $error("linked flags cleared apart");
    AST_MOD0: assert property ($past(cfg_o.modulator_pin_enable[0])
        && cfg_o.modulator_pin_enable[0] |-> modulator_data_pin0_o == $past(mod_bit_i[0]))
        else $error("modulator pin0 wrong");
    AST_MOD1_OFF: assert property (!$past(cfg_o.modulator_pin_enable[1])
        && !cfg_o.modulator_pin_enable[1] |-> !modulator_data_pin1_o)
        else $error("pin1 on while off");
    AST_LOOP_SAME: assert property (reg_rd_i && status_o.addr_loop == AFE_LOOP_SAME
        |=> reg_addr_o == $past(cur_a))
        else $error("address moved in same loop");
    AST_LOOP_TYPE: assert property (reg_rd_i && status_o.addr_loop == AFE_LOOP_TYPE
        && cur_a == `AFE_ADDR_CONFIG_CHANNEL_POWER |=> reg_addr_o == `AFE_ADDR_CTL_FIRST)
        else $error("type loop wrap wrong");
    AST_RATE: assert property (sample_rate_clock_o && seen_q |-> gap_q == per)
        else $error("rate tick period wrong");
endmodule
bind afe_ready_cfg_regs afe_rcr_asserts #(.MOD_DIV(MOD_DIV)) u_asserts (.*);
`default_nettype wire

// file: bench/afe_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module afe_host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output logic            fstart_o,
    output logic [4:0]      faddr_o,
    output logic            factive_o,
    output logic            rd_o,
    output logic            wr_o,
    output logic [7:0]      wdata_o
);
    initial {fstart_o, faddr_o, factive_o, rd_o, wr_o, wdata_o} = '0;
    // hold: frame open before first access
    task automatic xfer(input logic [4:0] a, input int n, input logic w,
                        input logic [7:0] wd, input int hold, output logic [23:0] d);
        d = 24'h00_0000;
        @(negedge clk_i);
        factive_o = 1'b1;
        repeat (hold) @(negedge clk_i);
        fstart_o = 1'b1;
        faddr_o = a;
        rd_o = !w;
        wr_o = w;
        wdata_o = wd;
        for (int i = 0; i < n; i++) begin
            @(negedge clk_i);
            d = {d[15:0], rdata_i};
            fstart_o = 1'b0;
            rd_o = !w && (i < n - 1);
            wr_o = w && (i < n - 1);
        end
        factive_o = 1'b0;
        // released lines show inverse
        faddr_o = ~faddr_o;
        wdata_o = ~wdata_o;
    endtask
endmodule
`default_nettype wire

// file: bench/test_afe_ready_and_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_afe_ready_and_config_regs;
    import afe_pkg::*;
    logic core_clk_i, rst_b_i = 1'b0, fs, fact, rd, wr, pin, oe, m0, m1, srclk, pin_q = 1'b1, dr;
    logic [4:0] fa, addr;
    logic [7:0] wd, phase = 8'h00, rdata;
    logic [23:0] ch0 = 24'h00_0000, ch1 = 24'h55_AA55;
    logic [1:0] mbit = 2'h0;
    afe_cfg_t cfg;
    afe_status_t st;
    int num_errors = 0, total_checks = 0, cyc = 0, t_tick = 0;
    int t_fall = 0, off = 0, falls = 0, ticks = 0;
    int o[3];
    // pull-up on released line
    assign dr = oe ? pin : 1'b1;
    afe_ready_cfg_regs #(.MOD_DIV(1)) u_dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
        .frame_start_i(fs), .frame_addr_i(fa), .frame_active_i(fact), .reg_rd_i(rd),
        .reg_wr_i(wr), .reg_wdata_i(wd), .phase_code_i(phase), .ch0_result_i(ch0),
        .ch1_result_i(ch1), .mod_bit_i(mbit), .reg_rdata_o(rdata), .reg_addr_o(addr),
        .cfg_o(cfg), .status_o(st), .ready_pin_o(pin), .ready_pin_oe_o(oe),
        .modulator_data_pin0_o(m0), .modulator_data_pin1_o(m1),
        .internal_master_clock_o(), .modulator_clock_o(), .sample_rate_clock_o(srclk));
    afe_host_model u_host (.clk_i(core_clk_i), .rdata_i(rdata), .fstart_o(fs),
        .faddr_o(fa), .factive_o(fact), .rd_o(rd), .wr_o(wr), .wdata_o(wd));
    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        pin_q <= dr;
        if (srclk) begin
            t_tick <= cyc;
            ticks <= ticks + 1;
        end
        if (pin_q && !dr) begin
            falls <= falls + 1;
            t_fall <= cyc;
            off <= cyc - t_tick;
        end
    end
    always @(negedge core_clk_i) mbit <= mbit + 2'h1;
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wfall(output int r);
        int f, n;
        f = falls;
        n = 0;
        while (falls == f) begin
            @(negedge core_clk_i);
            n++;
            if (n > 2000) begin
                num_errors++;
                $display("Error ready pulse wait expected pulse seen none");
                final_report();
            end
        end
        r = off;
    endtask
    task automatic wreg(input logic [4:0] a, input logic [7:0] v);
        logic [23:0] d;
        u_host.xfer(a, 1, 1'b1, v, 0, d);
        @(negedge core_clk_i);
    endtask
    task automatic rreg(input logic [4:0] a, input int n, input int h, output logic [23:0] d);
        u_host.xfer(a, n, 1'b0, 8'h00, h, d);
    endtask
    task automatic t_defaults();
        logic [23:0] d;
        chk("status", 24'(st), 24'h00_00A3);
        chk("config", 24'(cfg), 24'h00_100C);
        chk("idle_oe", 24'(oe), 24'h00_0000);
        rreg(5'h09, 3, 0, d);
        chk("rd_type", d, 24'hA3_100C);
        wreg(5'h0B, 8'h03);
        chk("config_channel_power", 24'(cfg[7:0]), 24'h00_0003);
        wreg(5'h09, 8'h00);
        chk("flags_wr", 24'(st), 24'h00_0003);
        rreg(5'h09, 2, 0, d);
        chk("rd_same", d, 24'h00_0303);
    endtask
    task automatic t_modes();
        int x, a, b;
        int mo[3] = '{2, 1, 0};
        phase = 8'h0A;
        for (int i = 0; i < 3; i++) begin
            wreg(5'h09, 8'hD0 | 8'(mo[i] << 2));
            wfall(x);
            wfall(o[i]);
        end
        chk("off_ch0", 24'(o[1]), 24'(o[0] + 10));
        chk("off_lag", 24'(o[2]), 24'(o[1]));
        repeat (8) @(negedge core_clk_i);
        chk("idle_drv", 24'({pin, oe}), 24'h00_0003);
        wreg(5'h09, 8'hDC);
        wfall(x);
        wfall(a);
        wfall(b);
        chk("both", 24'((a == o[0] && b == o[1]) || (a == o[1] && b == o[0])), 24'h1);
        phase = 8'hF6;
        wreg(5'h09, 8'hD0);
        wfall(x);
        wfall(a);
        chk("lag_neg", 24'(a), 24'(o[0]));
        phase = 8'h0A;
    endtask
    task automatic t_rates();
        int x, t1;
        logic [7:0] v[4] = '{8'h00, 8'h70, 8'h90, 8'hE0};
        wreg(5'h09, 8'hD8);
        foreach (v[i]) begin
            wreg(5'h0A, v[i]);
            wfall(x);
            wfall(x);
            t1 = t_fall;
            wfall(x);
            chk("period", 24'(t_fall - t1), 24'((32 << v[i][5:4]) * (1 << v[i][7:6])));
        end
        wreg(5'h0A, 8'h10);
    endtask
    task automatic t_off();
        int x, a, b, f;
        wreg(5'h09, 8'hDC);
        wreg(5'h0B, 8'h4C);
        wfall(x);
        wfall(a);
        wfall(b);
        chk("ch0_held", 24'(a == o[0] && b == o[0]), 24'h1);
        wreg(5'h0B, 8'h2C);
        wfall(x);
        wfall(a);
        wfall(b);
        chk("ch1_down", 24'(a == o[1] && b == o[1]), 24'h1);
        wreg(5'h09, 8'hD0);
        repeat (4) @(negedge core_clk_i);
        f = falls;
        repeat (200) @(negedge core_clk_i);
        chk("linked_off", 24'(falls), 24'(f));
        wreg(5'h0B, 8'h0C);
    endtask
    task automatic t_latency();
        int x, k;
        for (int lat = 0; lat < 2; lat++) begin
            wreg(5'h09, lat ? 8'hF8 : 8'hD8);
            wreg(5'h0B, 8'h8C);
            repeat (100) @(negedge core_clk_i);
            wreg(5'h0B, 8'h0C);
            k = ticks;
            wfall(x);
            chk("settle", 24'(ticks - k), lat ? 24'h4 : 24'h1);
        end
    endtask
    task automatic t_data();
        int x;
        logic [23:0] d;
        phase = 8'h00;
        wreg(5'h09, 8'h90);
        wreg(5'h0A, 8'h14);
        ch0 = 24'hAB_CDEF;
        wfall(x);
        wfall(x);
        ch0 = 24'h12_3456;
        rreg(5'h09, 1, 0, d);
        chk("flags_lnk", 24'(d[1:0]), 24'h0);
        chk("flags_set", 24'(st.ready_flags), 24'h3);
        rreg(5'h00, 3, 70, d);
        chk("frozen", d, 24'hAB_CDEF);
        rreg(5'h00, 3, 0, d);
        chk("fresh", d, 24'h12_3456);
        wreg(5'h0A, 8'h13);
        wfall(x);
        rreg(5'h00, 3, 0, d);
        chk("w16", d, 24'h12_3400);
    endtask
    initial begin
        repeat (3) @(negedge core_clk_i);
        rst_b_i = 1'b1;
        t_defaults();
        t_modes();
        t_rates();
        t_off();
        t_latency();
        t_data();
        final_report();
    end
endmodule
`default_nettype wire
